// file: src/oicp_port.sv
// i2c target port routing bytes to command decoder or display ram
// Summary of operation
// - answer address 0111100 with select low, 0111101 with select high
// - read/write bit: one means read, zero means write
// - after address comes control byte: continuation, select, six zeros
// - continuation zero: all following bytes are payload
// - select zero: following byte goes to command decoder
// - select one: following byte written to display ram at pointer
// - column pointer advances by one after each ram write
// - bus select low means spi, high means i2c
// - in i2c mode data/command pin is address select
`timescale 1ns/1ps
module oicp_port
  import oicp_pkg::*;
#(
  parameter int COLW  = COL_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic            MCLK,
  input  wire logic            RST_N,
  input  wire logic            BUS_SELECT_PIN,
  input  wire logic            CMD_DATA_PIN,
  input  wire logic            SCL,
  input  wire logic            SDA_IN,
  output logic                 SDA_OUT,
  output logic                 SDA_OE,
  output logic                 OUT_VALID,
  input  wire logic            OUT_READY,
  output logic                 OUT_IS_DATA,
  output logic [BYTE_W-1:0]    OUT_BYTE,
  output logic [COLW-1:0]      RAM_COL,
  input  wire logic            COL_LOAD,
  input  wire logic [COLW-1:0] COL_LOAD_VALUE,
  output logic                 READ_MODE,
  output logic                 BUSY
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] bs_sync;
  logic [1:0] sa_sync;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      bs_sync  <= 2'h0;
      sa_sync  <= 2'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], SCL};
      sda_sync <= {sda_sync[0], SDA_IN};
      bs_sync  <= {bs_sync[0], BUS_SELECT_PIN};
      sa_sync  <= {sa_sync[0], CMD_DATA_PIN};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic i2c_en;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [6:0] my_addr;
  assign scl_s    = scl_sync[1];
  assign sda_s    = sda_sync[1];
  assign i2c_en   = (bs_sync[1] == BS_I2C);
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c  = i2c_en && scl_s && scl_d && sda_d && !sda_s;
  assign stop_c   = i2c_en && scl_s && scl_d && !sda_d && sda_s;
  assign my_addr  = sa_sync[1] ? ADDR_HIGH : ADDR_LOW;

  // ==========================================================
  // bit engine and byte parser state
  oicp_bus_t       bstate;
  oicp_bus_t       next_bstate;
  oicp_parse_t     pstate;
  oicp_parse_t     next_pstate;
  logic [3:0]      bitcnt;
  logic [3:0]      next_bitcnt;
  logic [7:0]      shreg;
  logic [7:0]      next_shreg;
  logic            ack;
  logic            next_ack;
  logic            dc_sel;
  logic            next_dc_sel;
  logic            rd;
  logic            next_rd;
  logic [COLW-1:0] col;
  logic [COLW-1:0] next_col;
  logic            push;
  logic [8:0]      push_word;

  oicp_stream_if #(.W(9)) f_in ();
  oicp_stream_if #(.W(9)) f_out ();

  // byte ends as scl falls after bit eight: ack then never moves sda under high scl
  logic byte_done;
  assign byte_done = scl_fall && (bitcnt == BIT_ACK);

  // bit engine, parser, column pointer
  always_comb begin
    next_bstate = bstate;
    next_pstate = pstate;
    next_bitcnt = bitcnt;
    next_shreg  = shreg;
    next_ack    = ack;
    next_dc_sel = dc_sel;
    next_rd     = rd;
    next_col    = col;
    push        = 1'b0;
    push_word   = {dc_sel, shreg};
    if (scl_rise && bitcnt <= BIT_LAST) begin
      next_shreg = {shreg[6:0], sda_s};
    end
    if (scl_rise) begin
      next_bitcnt = (bitcnt == BIT_ACK) ? 4'h0 : bitcnt + 4'h1;
    end
    // ack release at the falling edge after the ninth clock
    if (scl_fall && bitcnt == 4'h0) begin
      next_ack = 1'b0;
    end
    unique case (bstate)
      BS_IDLE: begin
        next_bitcnt = 4'h0;
      end
      BS_ADDR: begin
        if (byte_done) begin
          if (next_shreg[7:1] == my_addr) begin
            next_rd     = (next_shreg[0] == RW_READ);
            next_ack    = 1'b1;
            next_bstate = BS_DATA;
          end else begin
            next_bstate = BS_SKIP;
          end
        end
      end
      BS_DATA: begin
        // withhold ack and push while fifo is full; byte dropped, nack shows it
        if (byte_done && !rd) begin
          unique case (pstate)
            PS_CTRL: begin
              next_ack    = 1'b1;
              next_dc_sel = next_shreg[CTL_DC_POS];
              // continuation selects stream or single byte
              next_pstate = next_shreg[CTL_CONT_POS] ? PS_ONE : PS_STREAM;
            end
            PS_ONE, PS_STREAM: begin
              push      = f_in.ready;
              push_word = {dc_sel, next_shreg};
              next_ack  = f_in.ready;
              if (f_in.ready && dc_sel) begin
                next_col = col + COLW'(1);
              end
              if (pstate == PS_ONE) begin
                next_pstate = PS_CTRL;
              end
            end
            default: next_pstate = PS_CTRL;
          endcase
        end
      end
      BS_SKIP: begin
        next_ack = 1'b0;
      end
      default: next_bstate = BS_IDLE;
    endcase
    if (COL_LOAD) begin
      next_col = COL_LOAD_VALUE;
    end
    // start then address; repeated start restarts the address
    if (start_c) begin
      next_bstate = BS_ADDR;
      next_bitcnt = 4'h0;
      next_ack    = 1'b0;
      next_pstate = PS_CTRL;
    end
    if (stop_c || !i2c_en) begin
      next_bstate = BS_IDLE;
      next_pstate = PS_CTRL;
      next_ack    = 1'b0;
      next_rd     = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bstate <= BS_IDLE;
      pstate <= PS_CTRL;
      bitcnt <= 4'h0;
      shreg  <= 8'h00;
      ack    <= 1'b0;
      dc_sel <= 1'b0;
      rd     <= 1'b0;
      col    <= COLW'(COL_RESET);
    end else begin
      bstate <= next_bstate;
      pstate <= next_pstate;
      bitcnt <= next_bitcnt;
      shreg  <= next_shreg;
      ack    <= next_ack;
      dc_sel <= next_dc_sel;
      rd     <= next_rd;
      col    <= next_col;
    end
  end

  // ==========================================================
  // fifo towards command decoder and display ram
  assign f_in.valid  = push;
  assign f_in.data   = push_word;
  assign f_out.ready = OUT_READY;

  oicp_fifo #(.W(9), .DEPTH(DEPTH)) u_fifo (
    .clk   (MCLK),
    .rst_n (RST_N),
    .in_s  (f_in),
    .out_s (f_out)
  );

  // outputs; reads return nothing so sda is only pulled for ack
  assign OUT_VALID   = f_out.valid;
  assign OUT_IS_DATA = f_out.data[8];
  assign OUT_BYTE    = f_out.data[7:0];
  assign SDA_OUT     = 1'b0;
  assign SDA_OE      = ack;
  assign RAM_COL     = col;
  assign READ_MODE   = rd;
  assign BUSY        = (bstate != BS_IDLE);

  // ==========================================================
  // checks
  // pointer step
  a_col_step: assert property (@(posedge MCLK) disable iff (!RST_N)
    (push && dc_sel && !COL_LOAD) |=> (col == $past(col) + COLW'(1)))
    else $error("column pointer did not advance");
  a_cmd_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    (push && !dc_sel && !COL_LOAD) |=> $stable(col))
    else $error("command moved column pointer");
  a_ram_route: assert property (@(posedge MCLK) disable iff (!RST_N)
    (push && push_word[8]) |=> OUT_VALID)
    else $error("ram byte not handed over");
  a_stop_reset: assert property (@(posedge MCLK) disable iff (!RST_N)
    stop_c |=> (pstate == PS_CTRL && bstate == BS_IDLE))
    else $error("stop did not reset parser");
  a_single_byte: assert property (@(posedge MCLK) disable iff (!RST_N)
    (push && pstate == PS_ONE && !start_c && !stop_c && i2c_en) |=> (pstate == PS_CTRL))
    else $error("single byte not followed by control");
  a_stream_stay: assert property (@(posedge MCLK) disable iff (!RST_N)
    (pstate == PS_STREAM && !start_c && !stop_c && i2c_en) |=> (pstate == PS_STREAM))
    else $error("stream mode left without stop");
  a_ack_addr: assert property (@(posedge MCLK) disable iff (!RST_N)
    (bstate == BS_ADDR && byte_done && next_shreg[7:1] == my_addr && !start_c && !stop_c
     && i2c_en) |=> ack)
    else $error("own address not acknowledged");
  a_no_ack_other: assert property (@(posedge MCLK) disable iff (!RST_N)
    (bstate == BS_SKIP) |-> !SDA_OE)
    else $error("drove sda for foreign address");
  a_spi_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    !i2c_en |=> (bstate == BS_IDLE && !SDA_OE))
    else $error("i2c active in spi mode");
  c_ram_write: cover property (@(posedge MCLK) disable iff (!RST_N) push && dc_sel);
  c_cmd_write: cover property (@(posedge MCLK) disable iff (!RST_N) push && !dc_sel);
  c_read_addr: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(rd));
  c_fifo_full: cover property (@(posedge MCLK) disable iff (!RST_N) !f_in.ready);
endmodule : oicp_port

// file: src/oicp_pkg.sv
// package of constants and types for the display i2c command/data port
package oicp_pkg;
  // ==========================================================
  // target addresses
  localparam logic [6:0] ADDR_LOW      = 7'h3c;  // 0111100
  localparam logic [6:0] ADDR_HIGH     = 7'h3d;  // 0111101
  // ==========================================================
  // control byte fields
  localparam int         CTL_CONT_POS  = 7;
  localparam int         CTL_DC_POS    = 6;
  localparam logic [5:0] CTL_ZERO      = 6'h00;
  // ==========================================================
  // widths, depths and reset values
  localparam int         BYTE_W        = 8;
  localparam int         FIFO_DEPTH    = 4;
  localparam int         COL_W         = 7;
  localparam logic [6:0] COL_RESET     = 7'h00;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic       RW_READ       = 1'b1;
  localparam logic       BS_I2C        = 1'b1;
  // ==========================================================
  // recommended host initialisation commands, for reference by tests
  localparam logic [7:0] CMD_DISP_OFF  = 8'hae;
  localparam logic [7:0] CMD_DISP_ON   = 8'haf;
  localparam logic [7:0] CMD_COL_WIN   = 8'h15;
  localparam logic [7:0] CMD_ROW_WIN   = 8'h75;
  localparam logic [7:0] CMD_CLK_DIV   = 8'hb3;
  localparam logic [7:0] CMD_FUNC_A    = 8'hab;
  localparam logic [7:0] CMD_PRECHG2   = 8'hb6;
  localparam logic [7:0] CMD_FUNC_B    = 8'hd5;

  // ==========================================================
  // parser and bit-engine states
  typedef enum logic [1:0] {PS_CTRL, PS_ONE, PS_STREAM} oicp_parse_t;
  typedef enum logic [1:0] {BS_IDLE, BS_ADDR, BS_DATA, BS_SKIP} oicp_bus_t;
endpackage : oicp_pkg

// file: src/oicp_stream_if.sv
// byte stream carrier between the port and its fifo
`timescale 1ns/1ps
interface oicp_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : oicp_stream_if

// file: src/oicp_fifo.sv
// small fifo with valid/ready on both sides
`timescale 1ns/1ps
module oicp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  oicp_stream_if.sink in_s,
  oicp_stream_if.src  out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  count;
  logic [AW:0]  next_count;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic         push;
  logic         pop;

  // ==========================================================
  // handshakes
  assign in_s.ready  = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // pointer and count update, wrap is power of two friendly only
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset, valid gates it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    count <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : oicp_fifo

// file: bench/oicp_host_model.sv
// i2c bus controller model that drives the display port's link pins
`timescale 1ns/1ps
module oicp_host_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ==========================================================
  // timing: half link period is four system clocks (900 ns bit with the spare clock)
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask : half
  // bus idles released: clock and data high through the pull-up
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // ==========================================================
  // framing; a spare clock between edges keeps data and clock apart
  task automatic start();
    sda_low = 1'b0;
    @(negedge mclk);
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    @(negedge mclk);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    @(negedge mclk);
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  // data only changes while the clock is low
  task automatic put_bit(input logic v);
    sda_low = ~v;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    @(negedge mclk);
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = ~sda;  // sampled late in the ninth high phase
    scl = 1'b0;
    @(negedge mclk);
  endtask : send_byte
  task automatic address(input logic [6:0] a, input logic rw, output logic ack);
    start();
    send_byte({a, rw}, ack);
  endtask : address
endmodule : oicp_host_model

// file: bench/testbench.sv
// self-checking bench for the display i2c command/data port
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module testbench import oicp_pkg::*;;
  logic        mclk, rst_n, bus_sel, addr_sel, scl, sda_low, sda, sda_out, sda_oe;
  logic        out_valid, out_ready, out_is_data, col_load, read_mode, busy, ack;
  logic [7:0]  out_byte;
  logic [6:0]  ram_col, col_val;
  logic [8:0]  head;
  logic [8:0]  exp_q[$];
  int          err_total = 0;
  int          cmp_count = 0;
  logic [7:0]  init_seq [16] = '{CMD_DISP_OFF, CMD_COL_WIN, 8'h00, 8'h3f, CMD_ROW_WIN, 8'h00,
    8'h7f, CMD_CLK_DIV, 8'h00, CMD_FUNC_A, 8'h01, CMD_PRECHG2, 8'h0f, CMD_FUNC_B, 8'h60,
    CMD_DISP_ON};
  // ==========================================================
  // clock, open-drain wire with pull-up, design and host
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  oicp_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  oicp_port dut (.MCLK(mclk), .RST_N(rst_n), .BUS_SELECT_PIN(bus_sel),
    .CMD_DATA_PIN(addr_sel), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .OUT_IS_DATA(out_is_data), .OUT_BYTE(out_byte), .RAM_COL(ram_col),
    .COL_LOAD(col_load), .COL_LOAD_VALUE(col_val), .READ_MODE(read_mode), .BUSY(busy));
  // ==========================================================
  // consumer: every popped word must match the oldest expected one
  always @(posedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      head = (exp_q.size() != 0) ? exp_q.pop_front() : 9'bx;
      `CHK({out_is_data, out_byte}, head)
    end
  end
  // ==========================================================
  // access tasks
  task automatic send(input logic [7:0] b, input logic exp_ack);
    host.send_byte(b, ack);
    `CHK(ack, exp_ack)
  endtask : send
  task automatic put(input logic [7:0] b, input logic is_data);
    // expectation first: the word may leave the fifo before the ninth clock ends
    exp_q.push_back({is_data, b});
    send(b, 1'b1);
  endtask : put
  task automatic open_wr(input logic [6:0] a, input logic exp_ack);
    host.address(a, 1'b0, ack);
    `CHK(ack, exp_ack)
  endtask : open_wr
  // bounded wait for the fifo to hand over everything expected
  task automatic settle(input string name);
    for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(negedge mclk);
    `CHK(exp_q.size(), 0)
    `CHK(busy, 1'b0)
    $display("test %s done", name);
  endtask : settle
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // watchdog: the tests need well under one millisecond
  initial begin
    #3_000_000;
    err_total++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, addr_sel, col_load, col_val} = '0;
    {bus_sel, out_ready} = 2'b11;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    `CHK({sda_out, sda_oe, out_valid, read_mode, busy}, 5'h00)
    `CHK(ram_col, 7'h00)
    repeat (5) @(negedge mclk);
    // address select pin picks one of two addresses
    for (int s = 0; s < 2; s++) begin
      addr_sel = s[0];
      repeat (5) @(negedge mclk);
      open_wr(7'h3c, s == 0);
      host.stop();
      open_wr(7'h3d, s == 1);
      host.stop();
    end
    addr_sel = 1'b0;
    settle("address");
    // one control byte then a stream of commands
    open_wr(7'h3c, 1'b1);
    send(8'h00, 1'b1);
    foreach (init_seq[i]) put(init_seq[i], 1'b0);
    host.stop();
    settle("command stream");
    // continuation set: control byte before every payload byte
    @(negedge mclk);
    col_val  = 7'h7e;
    col_load = 1'b1;
    @(negedge mclk);
    col_load = 1'b0;
    `CHK(ram_col, 7'h7e)
    open_wr(7'h3c, 1'b1);
    send(8'h80, 1'b1);
    put(8'haf, 1'b0);
    send(8'hc0, 1'b1);
    put(8'h55, 1'b1);
    send(8'hc0, 1'b1);
    put(8'h66, 1'b1);
    `CHK(ram_col, 7'h00)
    host.stop();
    settle("continuation");
    // fill the fifo with the consumer stalled, then overflow
    out_ready = 1'b0;
    open_wr(7'h3c, 1'b1);
    send(8'h40, 1'b1);
    for (int i = 0; i < 4; i++) put(8'ha0 + i[7:0], 1'b1);
    `CHK(ram_col, 7'h04)
    `CHK(busy, 1'b1)
    send(8'hee, 1'b0);
    host.stop();
    out_ready = 1'b1;
    settle("fifo full");
    // after a stop the first byte is a control byte again
    open_wr(7'h3c, 1'b1);
    send(8'h80, 1'b1);
    put(8'h3c, 1'b0);
    host.stop();
    settle("stop resets parser");
    // read direction is acknowledged and flagged
    host.address(7'h3c, 1'b1, ack);
    `CHK(ack, 1'b1)
    `CHK(read_mode, 1'b1)
    host.stop();
    open_wr(7'h3c, 1'b1);
    `CHK(read_mode, 1'b0)
    host.stop();
    settle("read mode");
    // serial peripheral mode leaves the i2c port deaf
    bus_sel = 1'b0;
    repeat (5) @(negedge mclk);
    open_wr(7'h3c, 1'b0);
    host.stop();
    bus_sel = 1'b1;
    settle("bus select");
    complete_run();
  end
endmodule : testbench
